// [wtc_top.sv]
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
module wtc_top (
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // scale channels, index 4 is the sum channel
  input wire logic [4:0][31:0] ch_gross,
  input wire logic [4:0][31:0] ch_disp,
  input wire logic [4:0][31:0] ch_rate,
  input wire logic [4:0] ch_motion,
  input wire logic [4:0] ch_update,
  input wire logic [31:0] app_value,
  // start inputs (keypad and discrete)
  input wire logic start_key,
  input wire logic start_din,
  // discrete outputs
  output logic feed,
  output logic fast_feed,
  output logic over_zone,
  output logic tol_ok,
  output logic under_zone,
  output logic [19:0] cmp_out,
  output logic cfg_err
);

  // relational and range evaluation shared by all comparators
  function automatic logic cmp_eval(input logic [2:0] op, input logic signed [31:0] v,
                                    input logic signed [31:0] lim,
                                    input logic signed [31:0] hi);
    logic r;
    r = 1'b0;
    case (op)
      wtc_pkg::WTC_OP_LT: r = v < lim;
      wtc_pkg::WTC_OP_LE: r = v <= lim;
      wtc_pkg::WTC_OP_EQ: r = v == lim;
      wtc_pkg::WTC_OP_GE: r = v >= lim;
      wtc_pkg::WTC_OP_GT: r = v > lim;
      wtc_pkg::WTC_OP_NE: r = v != lim;
      wtc_pkg::WTC_OP_IN: r = (v >= lim) && (v <= hi);
      wtc_pkg::WTC_OP_OUT: r = (v < lim) || (v > hi);
      default: r = 1'b0;
    endcase
    return r;
  endfunction : cmp_eval

  // tolerance as weight, or as percent of the target
  function automatic logic signed [31:0] tol_amt(input logic pct,
                                                 input logic signed [31:0] tol,
                                                 input logic signed [31:0] tgt);
    logic signed [63:0] prod;
    prod = 64'(tol) * 64'(tgt);
    prod = prod / wtc_pkg::WTC_PCT_DIV;
    return pct ? prod[31:0] : tol;
  endfunction : tol_amt

  // configuration and values held by software
  logic [31:0] tcfg; // target configuration
  logic signed [31:0] tgt, ptol, ntol, spill, fine, ulim, olim; // active target record
  logic [31:0] ccfg [20]; // comparator config words
  logic signed [31:0] clim [20]; // comparator limits
  logic signed [31:0] chi [20]; // comparator high limits
  logic err; // sticky range error
  logic done_feed, done_fast; // latch state in transfer mode
  logic [31:0] next_rdata;

  // target configuration fields
  wire [1:0] mode = tcfg[wtc_pkg::WTC_F_MODE +: 2];
  wire [1:0] ttype = tcfg[wtc_pkg::WTC_F_TTYPE +: 2];
  wire indep = tcfg[wtc_pkg::WTC_F_OTYPE];
  wire latch_en = tcfg[wtc_pkg::WTC_F_LATCH];
  wire motion_en = tcfg[wtc_pkg::WTC_F_MOTION];
  wire tsrc_gross = tcfg[wtc_pkg::WTC_F_TSRC];
  wire [2:0] tch = tcfg[wtc_pkg::WTC_F_TCH +: 3];

  // register decode
  wire cmp_space = (reg_addr >= wtc_pkg::WTC_A_CMP) && (reg_addr < wtc_pkg::WTC_A_CMP_END);
  // the bank spans 0x140 bytes, so the offset needs nine bits or the top four alias
  wire [8:0] cmp_off = 9'(reg_addr - wtc_pkg::WTC_A_CMP);
  wire [4:0] cmp_idx = cmp_off[8:4]; // comparator selected by address
  wire [3:0] cmp_fld = cmp_off[3:0];
  wire wr_ccfg = reg_we && cmp_space && (cmp_fld == wtc_pkg::WTC_O_CCFG);
  wire wr_clim = reg_we && cmp_space && (cmp_fld == wtc_pkg::WTC_O_CLIM);
  wire wr_chi = reg_we && cmp_space && (cmp_fld == wtc_pkg::WTC_O_CHI);

  // range check of the pending limit writes against the stored partner
  wire [2:0] sel_op = ccfg[cmp_idx][wtc_pkg::WTC_F_COP +: 3];
  wire sel_range = (sel_op == wtc_pkg::WTC_OP_IN) || (sel_op == wtc_pkg::WTC_OP_OUT);
  wire bad_hi = wr_chi && ($signed(reg_wdata) <= clim[cmp_idx]);
  wire bad_lim = wr_clim && sel_range && ($signed(reg_wdata) >= chi[cmp_idx]);
  wire bad_wr = bad_hi || bad_lim;
  wire err_clr = reg_we && (reg_addr == wtc_pkg::WTC_A_STAT) && reg_wdata[wtc_pkg::WTC_F_ERR];

  // start from keypad, discrete input or software
  wire sw_start = reg_we && (reg_addr == wtc_pkg::WTC_A_CTRL) && reg_wdata[0];
  wire start = start_key || start_din || sw_start;

  // target input: gross or displayed weight of the chosen channel
  wire tch_ok = tch < 3'(wtc_pkg::WTC_NCH);
  wire [2:0] tch_s = tch_ok ? tch : 3'h0;
  wire signed [31:0] tw = tsrc_gross ? ch_gross[tch_s] : ch_disp[tch_s];
  wire tupd = tch_ok && ch_update[tch_s];
  wire tmot = ch_motion[tch_s];

  // transfer thresholds: spill before target, fine feed before that
  wire signed [31:0] feed_pt = tgt - spill;
  wire signed [31:0] fast_pt = tgt - fine;
  wire feed_cond = tw < feed_pt;
  wire fast_cond = tw < fast_pt;
  wire feed_on = feed_cond && !(latch_en && done_feed);
  wire fast_on = fast_cond && !(latch_en && done_fast);
  // independent type holds the feed off while fast feed runs
  wire next_feed = (mode == wtc_pkg::WTC_MODE_XFER) && feed_on && !(indep && fast_on);
  wire next_fast = (mode == wtc_pkg::WTC_MODE_XFER) && fast_on;

  // over/under zone edges
  wire pct = ttype == wtc_pkg::WTC_TOL_PCT;
  wire wv = ttype == wtc_pkg::WTC_TOL_WV;
  wire signed [31:0] up_edge = wv ? olim : tgt + tol_amt(pct, ptol, tgt);
  wire signed [31:0] lo_edge = wv ? ulim : tgt - tol_amt(pct, ntol, tgt);
  wire ou_act = (mode == wtc_pkg::WTC_MODE_OU) && !(motion_en && tmot);
  wire next_over = ou_act && (tw > up_edge);
  wire next_under = ou_act && (tw < lo_edge);
  wire next_ok = ou_act && (tw <= up_edge) && (tw >= lo_edge);

  // per-comparator source selection and evaluation
  logic [19:0] cmp_hit; // comparison result for the current values
  logic [19:0] cmp_upd; // source channel delivered a new value
  genvar gi;
  generate
    for (gi = 0; gi < 20; gi++) begin : g_cmp
      wire [2:0] src = ccfg[gi][wtc_pkg::WTC_F_CSRC +: 3];
      wire [2:0] ch = ccfg[gi][wtc_pkg::WTC_F_CCH +: 3];
      wire ch_ok = ch < 3'(wtc_pkg::WTC_NCH);
      wire [2:0] ch_s = ch_ok ? ch : 3'h0;
      // weight sources arrive in the channel's primary units already
      wire signed [31:0] v = (src == wtc_pkg::WTC_SRC_DISP) ? ch_disp[ch_s] :
                             (src == wtc_pkg::WTC_SRC_GROSS) ? ch_gross[ch_s] :
                             (src == wtc_pkg::WTC_SRC_RATE) ? ch_rate[ch_s] : app_value;
      // rate is only meaningful once the channel's rate path runs
      wire valid_src = (src >= wtc_pkg::WTC_SRC_DISP) && (src <= wtc_pkg::WTC_SRC_APP);
      assign cmp_hit[gi] = valid_src && ch_ok && cmp_eval(ccfg[gi][wtc_pkg::WTC_F_COP +: 3],
                                                          v, clim[gi], chi[gi]);
      // application value has no update pulse of its own, so it is followed every cycle
      assign cmp_upd[gi] = (src == wtc_pkg::WTC_SRC_APP) || !ch_ok || ch_update[ch_s];
    end
  endgenerate

  // read mux, data valid in the cycle after the strobe
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (cmp_space && (cmp_idx < 5'(wtc_pkg::WTC_NCMP))) begin
      case (cmp_fld)
        wtc_pkg::WTC_O_CCFG: next_rdata = ccfg[cmp_idx];
        wtc_pkg::WTC_O_CLIM: next_rdata = clim[cmp_idx];
        wtc_pkg::WTC_O_CHI: next_rdata = chi[cmp_idx];
        default: next_rdata = 32'h0000_0000;
      endcase
    end else begin
      case (reg_addr)
        wtc_pkg::WTC_A_TCFG: next_rdata = tcfg;
        wtc_pkg::WTC_A_STAT: next_rdata = {23'h0, err, done_fast, done_feed, feed, fast_feed,
                                           over_zone, tol_ok, under_zone, 1'b0};
        wtc_pkg::WTC_A_COUT: next_rdata = {12'h000, cmp_out};
        wtc_pkg::WTC_A_TGT: next_rdata = tgt;
        wtc_pkg::WTC_A_PTOL: next_rdata = ptol;
        wtc_pkg::WTC_A_NTOL: next_rdata = ntol;
        wtc_pkg::WTC_A_SPILL: next_rdata = spill;
        wtc_pkg::WTC_A_FINE: next_rdata = fine;
        wtc_pkg::WTC_A_ULIM: next_rdata = ulim;
        wtc_pkg::WTC_A_OLIM: next_rdata = olim;
        default: next_rdata = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // read data register, zero when no read was made
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_re ? next_rdata : 32'h0000_0000;
    end
  end

  // target record and configuration writes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tcfg <= wtc_pkg::WTC_TCFG_RST;
      tgt <= 32'h0000_0000;
      ptol <= 32'h0000_0000;
      ntol <= 32'h0000_0000;
      spill <= 32'h0000_0000;
      fine <= 32'h0000_0000;
      ulim <= 32'h0000_0000;
      olim <= 32'h0000_0000;
    end else if (reg_we) begin
      case (reg_addr)
        wtc_pkg::WTC_A_TCFG: tcfg <= reg_wdata;
        wtc_pkg::WTC_A_TGT: tgt <= reg_wdata;
        wtc_pkg::WTC_A_PTOL: ptol <= reg_wdata;
        wtc_pkg::WTC_A_NTOL: ntol <= reg_wdata;
        wtc_pkg::WTC_A_SPILL: spill <= reg_wdata;
        wtc_pkg::WTC_A_FINE: fine <= reg_wdata;
        wtc_pkg::WTC_A_ULIM: ulim <= reg_wdata;
        wtc_pkg::WTC_A_OLIM: olim <= reg_wdata;
        default: ;
      endcase
    end
  end

  // comparator bank writes; a bad limit write leaves the old value
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 20; i++) begin
        ccfg[i] <= wtc_pkg::WTC_CCFG_RST;
        clim[i] <= 32'h0000_0000;
        chi[i] <= 32'h0000_0000;
      end
    end else if (cmp_idx < 5'(wtc_pkg::WTC_NCMP)) begin
      if (wr_ccfg) begin
        ccfg[cmp_idx] <= reg_wdata;
      end
      if (wr_clim && !bad_lim) begin
        clim[cmp_idx] <= reg_wdata;
      end
      if (wr_chi && !bad_hi) begin
        chi[cmp_idx] <= reg_wdata;
      end
    end
  end

  // sticky error; a new fault wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      err <= 1'b0;
    end else if (bad_wr && cmp_space) begin
      err <= 1'b1;
    end else if (err_clr) begin
      err <= 1'b0;
    end
  end
  assign cfg_err = err;

  // transfer latches: set when a threshold is crossed, cleared by start
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      done_feed <= 1'b0;
      done_fast <= 1'b0;
    end else if (tupd && latch_en && (mode == wtc_pkg::WTC_MODE_XFER) && !feed_cond) begin
      done_feed <= 1'b1;
      done_fast <= 1'b1;
    end else if (tupd && latch_en && (mode == wtc_pkg::WTC_MODE_XFER) && !fast_cond) begin
      done_fast <= 1'b1;
      done_feed <= start ? 1'b0 : done_feed;
    end else if (start) begin
      done_feed <= 1'b0;
      done_fast <= 1'b0;
    end
  end

  // target outputs refresh on each update of the target channel
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      feed <= 1'b0;
      fast_feed <= 1'b0;
      over_zone <= 1'b0;
      tol_ok <= 1'b0;
      under_zone <= 1'b0;
    end else if (tupd) begin
      feed <= next_feed;
      fast_feed <= next_fast;
      over_zone <= next_over;
      tol_ok <= next_ok;
      under_zone <= next_under;
    end else if (mode != wtc_pkg::WTC_MODE_XFER) begin
      // leaving transfer mode drops the feeds at once
      feed <= 1'b0;
      fast_feed <= 1'b0;
    end
  end

  // comparator outputs refresh on their own channel's update, or every cycle for the application source or an invalid channel
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_out <= 20'h00000;
    end else begin
      for (int i = 0; i < 20; i++) begin
        if (cmp_upd[i]) begin
          cmp_out[i] <= cmp_hit[i];
        end
      end
    end
  end

endmodule : wtc_top

// [wtc_pkg.sv]
// Functional notes
// - twenty independent comparators drive discrete outputs
// - source none disables comparator, default none
// - comparator channel is scale 1-4 or sum
// - relational operators compare source against limit
// - within/outside compare against limit..high band
// - weight limits use channel primary units
// - target input is gross or displayed weight
// - transfer mode drops feed at target; the code drops it at target minus spill
// - over/under classifies load against zone
// - tolerance is deviation or percent of target
// - positive tolerance upper edge, negative lower edge
// - weight-value type uses only under/over limits
// - concurrent or independent two-speed feed outputs
// - fast feed stops at fine feed point
// - per-record spill value is kept
// - latched outputs stay off until start
// - unlatched outputs follow comparison directly
// - motion check gates zone outputs
// - motion check off by default
// - reject high limit not above limit, flag
package wtc_pkg;
  localparam int unsigned WTC_NCMP = 20; // comparator count
  localparam int unsigned WTC_NCH = 5; // four scales plus sum channel
  localparam int unsigned WTC_AW = 12; // register address width
  // register offsets (byte addresses)
  localparam logic [11:0] WTC_A_TCFG = 12'h000; // target configuration
  localparam logic [11:0] WTC_A_STAT = 12'h004; // status and error flag
  localparam logic [11:0] WTC_A_CTRL = 12'h008; // software start strobe
  localparam logic [11:0] WTC_A_COUT = 12'h00c; // comparator outputs
  localparam logic [11:0] WTC_A_TGT = 12'h010; // target value
  localparam logic [11:0] WTC_A_PTOL = 12'h014; // positive tolerance
  localparam logic [11:0] WTC_A_NTOL = 12'h018; // negative tolerance
  localparam logic [11:0] WTC_A_SPILL = 12'h01c; // spill
  localparam logic [11:0] WTC_A_FINE = 12'h020; // fine feed value
  localparam logic [11:0] WTC_A_ULIM = 12'h024; // under limit
  localparam logic [11:0] WTC_A_OLIM = 12'h028; // over limit
  localparam logic [11:0] WTC_A_CMP = 12'h100; // first comparator block
  localparam logic [11:0] WTC_A_CMP_END = 12'h240; // end of comparator blocks
  localparam logic [3:0] WTC_O_CCFG = 4'h0; // comparator config word
  localparam logic [3:0] WTC_O_CLIM = 4'h4; // comparator limit
  localparam logic [3:0] WTC_O_CHI = 4'h8; // comparator high limit
  // target configuration field positions
  localparam int unsigned WTC_F_MODE = 0; // 2 bits
  localparam int unsigned WTC_F_TTYPE = 2; // 2 bits
  localparam int unsigned WTC_F_OTYPE = 4; // 1 = independent
  localparam int unsigned WTC_F_LATCH = 5;
  localparam int unsigned WTC_F_MOTION = 6;
  localparam int unsigned WTC_F_TSRC = 7; // 1 = gross, 0 = displayed
  localparam int unsigned WTC_F_TCH = 8; // 3 bits
  localparam int unsigned WTC_F_ERR = 8; // error flag in status
  // comparator config field positions
  localparam int unsigned WTC_F_CSRC = 0; // 3 bits
  localparam int unsigned WTC_F_CCH = 4; // 3 bits
  localparam int unsigned WTC_F_COP = 8; // 3 bits
  localparam logic [31:0] WTC_TCFG_RST = 32'h0000_0000; // none, motion check off
  localparam logic [31:0] WTC_CCFG_RST = 32'h0000_0000; // source none
  localparam logic signed [63:0] WTC_PCT_DIV = 64'sh64; // percent divisor
  typedef enum logic [1:0] {
    WTC_MODE_NONE = 2'b00, WTC_MODE_XFER = 2'b01, WTC_MODE_OU = 2'b10
  } wtc_mode_e;
  typedef enum logic [1:0] {
    WTC_TOL_DEV = 2'b00, WTC_TOL_PCT = 2'b01, WTC_TOL_WV = 2'b10
  } wtc_tol_e;
  typedef enum logic [2:0] {
    WTC_SRC_NONE = 3'b000, WTC_SRC_DISP = 3'b001, WTC_SRC_GROSS = 3'b010,
    WTC_SRC_RATE = 3'b011, WTC_SRC_APP = 3'b100
  } wtc_src_e;
  typedef enum logic [2:0] {
    WTC_OP_LT = 3'b000, WTC_OP_LE = 3'b001, WTC_OP_EQ = 3'b010, WTC_OP_GE = 3'b011,
    WTC_OP_GT = 3'b100, WTC_OP_NE = 3'b101, WTC_OP_IN = 3'b110, WTC_OP_OUT = 3'b111
  } wtc_op_e;
endpackage : wtc_pkg

// [wtc_scale_model.sv]
`timescale 1ns/100ps
// scale channel model: a request becomes one sample plus its update pulse
module wtc_scale_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic req,
  input wire logic [2:0] req_ch,
  input wire logic [31:0] req_gross,
  input wire logic [31:0] req_disp,
  input wire logic req_motion,
  output logic [4:0][31:0] ch_gross = '0,
  output logic [4:0][31:0] ch_disp = '0,
  output logic [4:0][31:0] ch_rate = '0,
  output logic [4:0] ch_motion = '0,
  output logic [4:0] ch_update = '0
);
  // values hold between samples, as a real channel keeps its last reading
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ch_update <= 5'h00;
    end else begin
      ch_update <= req ? (5'h01 << req_ch) : 5'h00;
      if (req) begin
        ch_gross[req_ch] <= req_gross;
        ch_disp[req_ch] <= req_disp;
        ch_rate[req_ch] <= $signed(req_gross) >>> 1; // rate always enabled
        ch_motion[req_ch] <= req_motion;
      end
    end
  end
endmodule : wtc_scale_model

// [wtc_checker.sv]
`timescale 1ns/100ps
module wtc_checker (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  input wire logic [4:0] ch_update,
  input wire logic [31:0] app_value,
  input wire logic start_key,
  input wire logic start_din,
  input wire logic feed,
  input wire logic fast_feed,
  input wire logic over_zone,
  input wire logic tol_ok,
  input wire logic under_zone,
  input wire logic [19:0] cmp_out,
  input wire logic cfg_err
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // nothing that may move an output: no update now, no write or start now or just before
  sequence s_quiet;
    ch_update == 5'h00 && !reg_we && !$past(reg_we) && !start_key && !start_din
      && !$past(start_key) && !$past(start_din);
  endsequence
  // read strobe to one address
  sequence s_read(logic [11:0] a);
    reg_re && reg_addr == a;
  endsequence
  a_rdata_idle: assert property (!reg_re |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_cmp_read: assert property (s_read(wtc_pkg::WTC_A_COUT) |=> reg_rdata[19:0] == $past(cmp_out))
    else $error("comparator readback wrong");
  a_stat_read: assert property (s_read(wtc_pkg::WTC_A_STAT) |=> reg_rdata[8] == $past(cfg_err)
    && reg_rdata[3] == $past(over_zone) && reg_rdata[2] == $past(tol_ok)
    && reg_rdata[1] == $past(under_zone) && reg_rdata[5] == $past(feed))
    else $error("status readback wrong");
  a_err_sticky: assert property (cfg_err && !(reg_we && reg_addr == wtc_pkg::WTC_A_STAT) |=> cfg_err)
    else $error("error flag dropped without clear");
  a_err_cause: assert property ($rose(cfg_err) |-> $past(reg_we) && $past(reg_addr) >= 12'h100)
    else $error("error flag rose without a limit write");
  a_err_clear: assert property (reg_we && reg_addr == wtc_pkg::WTC_A_STAT && reg_wdata[8] |=> !cfg_err)
    else $error("error flag not cleared");
  a_zone_onehot: assert property ($onehot0({over_zone, tol_ok, under_zone}))
    else $error("more than one zone output on");
  a_zone_hold: assert property (s_quiet |=> $stable({over_zone, tol_ok, under_zone}))
    else $error("zone outputs moved without a sample");
  a_feed_hold: assert property (s_quiet |=> $stable({feed, fast_feed}))
    else $error("feed outputs moved without a sample");
  a_cmp_hold: assert property (s_quiet ##0 $stable(app_value) |=> $stable(cmp_out))
    else $error("comparator outputs moved without a sample");
endmodule : wtc_checker
bind wtc_top wtc_checker u_chk (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .ch_update(ch_update), .app_value(app_value), .start_key(start_key),
  .start_din(start_din), .feed(feed), .fast_feed(fast_feed), .over_zone(over_zone),
  .tol_ok(tol_ok), .under_zone(under_zone), .cmp_out(cmp_out), .cfg_err(cfg_err));

// [wtc_top_test.sv]
`timescale 1ns/100ps
module wtc_top_test;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] app_value = 32'h0;
  logic start_key = 1'b0;
  logic start_din = 1'b0;
  logic req = 1'b0;
  logic [2:0] req_ch = 3'h0;
  logic [31:0] req_gross = 32'h0;
  logic [31:0] req_disp = 32'h0;
  logic req_motion = 1'b0;
  logic [4:0][31:0] ch_gross, ch_disp, ch_rate;
  logic [4:0] ch_motion, ch_update;
  logic [31:0] reg_rdata, rdv;
  logic feed, fast_feed, over_zone, tol_ok, under_zone, cfg_err;
  logic [19:0] cmp_out;
  logic [7:0] expc;
  int error_cnt = 0;
  int checks_done = 0;
  int lim, hi, v, ch;
  int wt[3] = '{500, 800, 950}; // below fine point, at fine point, at spill point
  logic [1:0] xexp[2][3] = '{'{2'b11, 2'b10, 2'b00}, '{2'b01, 2'b10, 2'b00}};
  int ow[4] = '{1011, 1010, 980, 979}; // both zone edges and one step past
  logic [2:0] oexp[4] = '{3'b100, 3'b010, 3'b010, 3'b001};
  wtc_top uut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .ch_gross,
    .ch_disp, .ch_rate, .ch_motion, .ch_update, .app_value, .start_key, .start_din, .feed,
    .fast_feed, .over_zone, .tol_ok, .under_zone, .cmp_out, .cfg_err);
  wtc_scale_model u_scale (.mclk, .rstn, .req, .req_ch, .req_gross, .req_disp, .req_motion,
    .ch_gross, .ch_disp, .ch_rate, .ch_motion, .ch_update);
  // free-running 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // one channel sample; outputs settle one edge after the update pulse
  task automatic upd(input int c, input int g, input int d, input logic m);
    @(posedge mclk);
    req <= 1'b1;
    req_ch <= 3'(c);
    req_gross <= 32'(g);
    req_disp <= 32'(d);
    req_motion <= m;
    @(posedge mclk);
    req <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : upd
  // high goes wide first so the limit write is never refused
  task automatic cset(input int i, input int s, input int c, input int op, input int l, input int h);
    logic [11:0] b;
    b = 12'h100 + 12'(16 * i);
    wr(b, 32'(s | (c << 4) | (op << 8)));
    wr(b + 12'h008, 32'h7fff_ffff);
    wr(b + 12'h004, 32'(l));
    wr(b + 12'h008, 32'(h));
  endtask : cset
  function automatic logic cexp(input int op, input int x, input int l, input int h);
    case (op)
      0: return x < l;
      1: return x <= l;
      2: return x == l;
      3: return x >= l;
      4: return x > l;
      5: return x != l;
      6: return x >= l && x <= h;
      default: return x < l || x > h;
    endcase
  endfunction : cexp
  // watchdog against a hang
  initial begin
    repeat (50000) @(posedge mclk);
    error_cnt++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h9ed7cad4));
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(wtc_pkg::WTC_A_TCFG, rdv);
    chk(rdv, wtc_pkg::WTC_TCFG_RST);
    rd(wtc_pkg::WTC_A_CMP, rdv);
    chk(rdv, wtc_pkg::WTC_CCFG_RST);
    rd(12'h7f0, rdv);
    chk(rdv, 32'h0);
    $display("test reset done");
    // every operator on random limits, with boundary values, over all channels
    for (int n = 0; n < 12; n++) begin
      ch = n % 5;
      lim = int'($urandom_range(100)) - 50;
      hi = lim + 1 + int'($urandom_range(19));
      v = (n % 4 == 0) ? lim : (n % 4 == 1) ? hi : (n % 4 == 2) ? lim - 1 : lim + 25;
      for (int i = 0; i < 8; i++) begin
        cset(i, (n % 2 == 1) ? 1 : 2, ch, i, lim, hi);
        expc[i] = cexp(i, v, lim, hi);
      end
      upd(ch, (n % 2 == 1) ? ~v : v, (n % 2 == 1) ? v : ~v, 1'b0);
      chk(32'(cmp_out[7:0]), 32'(expc));
      rd(wtc_pkg::WTC_A_COUT, rdv);
      chk(rdv, {24'h0, expc});
    end
    $display("test operators done");
    cset(8, 3, 3, 4, 100, 200);
    cset(9, 4, 0, 2, 77, 100);
    cset(10, 0, 3, 3, -1000, 0);
    cset(11, 2, 5, 3, -1000, 0); // channel index past the sum channel
    cset(19, 2, 3, 3, 100, 200); // last comparator of the bank
    app_value <= 32'd77;
    upd(3, 300, 300, 1'b0);
    chk(32'({cmp_out[19], cmp_out[11:8]}), 32'h13);
    app_value <= 32'd78;
    upd(3, 100, 100, 1'b0);
    chk(32'({cmp_out[19], cmp_out[11:8]}), 32'h10);
    $display("test sources done");
    cset(0, 2, 0, 6, 10, 30);
    wr(12'h108, 32'd10);
    @(posedge mclk);
    #1 chk(32'(cfg_err), 32'h1);
    wr(wtc_pkg::WTC_A_STAT, 32'h100);
    #1 chk(32'(cfg_err), 32'h0);
    wr(12'h104, 32'd40);
    @(posedge mclk);
    #1 chk(32'(cfg_err), 32'h1);
    upd(0, 20, 20, 1'b0);
    chk(32'(cmp_out[0]), 32'h1);
    wr(wtc_pkg::WTC_A_STAT, 32'h100);
    $display("test range errors done");
    wr(wtc_pkg::WTC_A_TGT, 32'd1000);
    wr(wtc_pkg::WTC_A_FINE, 32'd200);
    wr(wtc_pkg::WTC_A_SPILL, 32'd50);
    for (int k = 0; k < 2; k++) begin
      wr(wtc_pkg::WTC_A_TCFG, 32'h281 | 32'(k << 4));
      for (int j = 0; j < 3; j++) begin
        upd(2, wt[j], ~wt[j], 1'b0);
        chk(32'({feed, fast_feed}), 32'(xexp[k][j]));
      end
    end
    wr(wtc_pkg::WTC_A_TCFG, 32'h201);
    upd(2, 950, 500, 1'b0);
    chk(32'({feed, fast_feed}), 32'h3);
    wr(wtc_pkg::WTC_A_TCFG, 32'h2a1);
    for (int k = 0; k < 3; k++) begin
      upd(2, 950, 0, 1'b0);
      upd(2, 500, 0, 1'b0);
      chk(32'({feed, fast_feed}), 32'h0);
      rd(wtc_pkg::WTC_A_STAT, rdv);
      chk(rdv, 32'h0000_00c0);
      // third pass clears the latches through the software start strobe
      if (k == 2) begin
        wr(wtc_pkg::WTC_A_CTRL, 32'h1);
      end else begin
        @(posedge mclk);
        start_key <= (k == 0);
        start_din <= (k == 1);
        @(posedge mclk);
        start_key <= 1'b0;
        start_din <= 1'b0;
      end
      upd(2, 500, 0, 1'b0);
      chk(32'({feed, fast_feed}), 32'h3);
    end
    $display("test transfer done");
    wr(wtc_pkg::WTC_A_PTOL, 32'd10);
    wr(wtc_pkg::WTC_A_NTOL, 32'd20);
    wr(wtc_pkg::WTC_A_ULIM, 32'd980);
    wr(wtc_pkg::WTC_A_OLIM, 32'd1010);
    for (int t = 0; t < 3; t++) begin
      if (t == 1) wr(wtc_pkg::WTC_A_PTOL, 32'd1);
      if (t == 1) wr(wtc_pkg::WTC_A_NTOL, 32'd2);
      if (t == 2) wr(wtc_pkg::WTC_A_TGT, 32'd5000);
      wr(wtc_pkg::WTC_A_TCFG, 32'h182 | 32'(t << 2));
      for (int j = 0; j < 4; j++) begin
        upd(1, ow[j], ~ow[j], 1'b1);
        chk(32'({over_zone, tol_ok, under_zone}), 32'(oexp[j]));
      end
    end
    wr(wtc_pkg::WTC_A_TCFG, 32'h1ca);
    upd(1, 1011, 0, 1'b1);
    chk(32'({over_zone, tol_ok, under_zone}), 32'h0);
    upd(1, 1011, 0, 1'b0);
    chk(32'({over_zone, tol_ok, under_zone}), 32'h4);
    $display("test over under done");
    complete_run();
  end
endmodule : wtc_top_test
